// file: obcd_byte_cell.sv
// One non-volatile configuration byte cell with programming-mode access.
// Assumes the caller gates strobes with programming mode; content survives reset.
`timescale 1ns/1ps
`default_nettype none
module obcd_byte_cell (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Access
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_force_ones,
  // Content
  output logic [7:0] o_value
);
  logic [7:0] cell_r;
  logic init_done_r = 1'b0;

  // Storage powers up erased; the first clock after power takes the erased value.
  always_ff @(posedge i_sys_clk) begin
    if (!init_done_r) begin
      cell_r <= obcd_pkg::OBCD_ERASED_BYTE;
    end else if (i_wr) begin
      cell_r <= i_wdata | i_force_ones;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    init_done_r <= 1'b1;
  end

  assign o_value = cell_r;
  wire unused_rst = i_rst;
endmodule
`default_nettype wire

// file: obcd_pkg.sv
// Package for the option byte configuration decoder: field positions, reset values, enums.
// Assumes a single 250 MHz system clock and a synchronous active-high reset.
package obcd_pkg;

  // Erased non-volatile content reads all ones.
  localparam logic [7:0] OBCD_ERASED_BYTE = 8'hff;

  // First byte field positions.
  localparam int OBCD_B0_IRQ_MAP_BIT = 1;
  localparam int OBCD_B0_PROTECT_BIT = 0;

  // Second byte field positions.
  localparam int OBCD_B1_CLK_FILTER_OFF_BIT = 7;
  localparam int OBCD_B1_OSC_HI = 6;
  localparam int OBCD_B1_OSC_LO = 4;
  localparam int OBCD_B1_BOR_HI = 3;
  localparam int OBCD_B1_BOR_LO = 2;
  localparam int OBCD_B1_WDOG_HALT_BIT = 1;
  localparam int OBCD_B1_WDOG_SOFT_BIT = 0;

  // Program memory address width and last byte address.
  localparam int OBCD_PMEM_AW = 13;
  localparam logic [12:0] OBCD_PMEM_LAST = 13'h1fff;

  // Port group widths.
  localparam int OBCD_PA_W = 8;
  localparam int OBCD_PB_W = 8;
  localparam int OBCD_PC_W = 6;

  typedef enum logic [2:0] {
    OBCD_OSC_HS_RES,
    OBCD_OSC_MS_RES,
    OBCD_OSC_MP_RES,
    OBCD_OSC_LP_RES,
    OBCD_OSC_EXT_RC,
    OBCD_OSC_INT_RC,
    OBCD_OSC_EXT_CLK
  } obcd_osc_t;

  typedef enum logic [1:0] {
    OBCD_BOR_LOWEST,
    OBCD_BOR_MEDIUM,
    OBCD_BOR_HIGHEST,
    OBCD_BOR_OFF
  } obcd_bor_t;

  // Decoded static configuration handed to the surrounding units.
  typedef struct packed {
    logic irq_port_map_sel;
    logic readout_protect;
    logic clock_glitch_filter;
    obcd_osc_t main_osc_select;
    obcd_bor_t brownout_threshold_sel;
    logic wdog_halt_reset;
    logic wdog_soft_start;
    logic wdog_hw_enable;
  } obcd_cfg_t;

  // Programming-mode access to the two bytes.
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [7:0] wdata;
  } obcd_prog_req_t;

endpackage

// file: obcd_tool_model.sv
// Programming tool model that reads and writes the option bytes.
// Each access first waits for a rising edge, so two calls never drive in one time step.
`timescale 1ns/1ps
`default_nettype none
module obcd_tool_model (
  // Clock
  input wire logic i_sys_clk,
  // Programming port
  input wire logic [7:0] i_prog_rdata,
  output logic o_prog_mode,
  output var obcd_pkg::obcd_prog_req_t o_prog_req
);
  logic mode = 1'b1;
  logic [7:0] rd_val;
  assign o_prog_mode = mode;
  initial o_prog_req = '0;
  task automatic acc(input logic w, input logic s, input logic [7:0] d);
    @(posedge i_sys_clk);
    #1;
    o_prog_req = '{wr: w, rd: !w, sel: s, wdata: d};
    @(posedge i_sys_clk);
    #1;
    rd_val = i_prog_rdata;
    // Released data lines show the inverse so stale values never pass.
    o_prog_req = '{wr: 1'b0, rd: 1'b0, sel: s, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// file: obcd_top.sv
// Option byte configuration decoder: stores two option bytes, latches them at reset and
// drives the decoded static configuration and the program memory erase sweep.
// Assumes the programming tool toggles i_prog_mode and strobes only while it is high.
//
// Notes on behaviour
// - Option bytes have no memory address; reachable only in programming mode.
// - Unprogrammed option bytes read as all ones.
// - Map bit 1 puts port C on irq1; 0 puts port C on irq0.
// - Protection bit 1 blocks external program memory read-out; 0 allows it.
// - Clearing protection erases whole program memory with latched data, not option bytes.
// - Clock filter bit 0 enables filter, 1 disables it.
// - Oscillator bits pick external clock, internal RC, external RC or resonator.
// - Voltage bits: 11 off, 10 highest, 01 medium, 00 lowest threshold.
// - Halt while watchdog runs: 1 resets, 0 halts without reset.
// - Watchdog bit 0 hardware always on; 1 software enabled.
`timescale 1ns/1ps
`default_nettype none
module obcd_top (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Programming mode access
  input wire logic i_prog_mode,
  input wire obcd_pkg::obcd_prog_req_t i_prog_req,
  output logic [7:0] o_prog_rdata,
  output logic o_prog_rvalid,
  // Interrupt routing of port lines
  input wire logic [7:0] i_port_a_irq,
  input wire logic [7:0] i_port_b_irq,
  input wire logic [5:0] i_port_c_irq,
  output logic o_ext_irq0,
  output logic o_ext_irq1,
  // External program memory read-out gate
  input wire logic i_ext_readout_req,
  output logic o_ext_readout_allow,
  // Program memory erase sweep
  input wire logic [7:0] i_pmem_latch_data,
  output logic o_pmem_erase_we,
  output logic [12:0] o_pmem_erase_addr,
  output logic [7:0] o_pmem_erase_data,
  output logic o_pmem_erase_busy,
  // Watchdog halt handling
  input wire logic i_halt_entry,
  input wire logic i_wdog_running,
  output logic o_halt_reset_req,
  output logic o_halt_allow,
  // Decoded configuration
  output obcd_pkg::obcd_cfg_t o_cfg
);

  typedef enum logic [1:0] {
    OBCD_ER_IDLE,
    OBCD_ER_SWEEP,
    OBCD_ER_DONE
  } obcd_er_state_t;

  logic [7:0] byte0_val;
  logic [7:0] byte1_val;
  logic wr0;
  logic wr1;
  logic [7:0] byte0_r;
  logic [7:0] byte1_r;
  obcd_pkg::obcd_cfg_t cfg_nxt;
  obcd_er_state_t er_state_r = OBCD_ER_IDLE;
  logic [12:0] er_addr_r;
  logic erase_start;

  // Writes land only in programming mode; no address path exists besides this port.
  assign wr0 = i_prog_mode && i_prog_req.wr && !i_prog_req.sel;
  assign wr1 = i_prog_mode && i_prog_req.wr && i_prog_req.sel;

  // Reserved upper bits of the first byte always hold ones.
  obcd_byte_cell u_byte0 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr(wr0),
    .i_wdata(i_prog_req.wdata),
    .i_force_ones(8'hfc),
    .o_value(byte0_val)
  );

  obcd_byte_cell u_byte1 (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr(wr1),
    .i_wdata(i_prog_req.wdata),
    .i_force_ones(8'h00),
    .o_value(byte1_val)
  );

  // Clearing protection by a programming write starts the erase.
  assign erase_start = wr0 && byte0_val[obcd_pkg::OBCD_B0_PROTECT_BIT]
                       && !i_prog_req.wdata[obcd_pkg::OBCD_B0_PROTECT_BIT];

  // A read strobe outside programming mode gets no answer at all.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prog_rvalid <= 1'b0;
    end else begin
      o_prog_rvalid <= i_prog_mode && i_prog_req.rd;
    end
  end

  // Read data holds until the next accepted read; reset clears it to zero.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_prog_rdata <= 8'h00;
    end else if (i_prog_mode && i_prog_req.rd) begin
      o_prog_rdata <= i_prog_req.sel ? byte1_val : byte0_val;
    end
  end

  // Latch the raw bytes while reset is held; they do not follow later writes.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      byte0_r <= byte0_val;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      byte1_r <= byte1_val;
    end
  end

  // Decode of the latched bytes.
  always_comb begin
    cfg_nxt = '0;
    cfg_nxt.irq_port_map_sel = byte0_r[obcd_pkg::OBCD_B0_IRQ_MAP_BIT];
    cfg_nxt.readout_protect = byte0_r[obcd_pkg::OBCD_B0_PROTECT_BIT];
    cfg_nxt.clock_glitch_filter = !byte1_r[obcd_pkg::OBCD_B1_CLK_FILTER_OFF_BIT];
    case (byte1_r[obcd_pkg::OBCD_B1_OSC_HI:obcd_pkg::OBCD_B1_OSC_LO])
      3'h7: cfg_nxt.main_osc_select = obcd_pkg::OBCD_OSC_EXT_CLK;
      3'h6: cfg_nxt.main_osc_select = obcd_pkg::OBCD_OSC_INT_RC;
      3'h5, 3'h4: cfg_nxt.main_osc_select = obcd_pkg::OBCD_OSC_EXT_RC;
      3'h3: cfg_nxt.main_osc_select = obcd_pkg::OBCD_OSC_LP_RES;
      3'h2: cfg_nxt.main_osc_select = obcd_pkg::OBCD_OSC_MP_RES;
      3'h1: cfg_nxt.main_osc_select = obcd_pkg::OBCD_OSC_MS_RES;
      default: cfg_nxt.main_osc_select = obcd_pkg::OBCD_OSC_HS_RES;
    endcase
    case (byte1_r[obcd_pkg::OBCD_B1_BOR_HI:obcd_pkg::OBCD_B1_BOR_LO])
      2'h3: cfg_nxt.brownout_threshold_sel = obcd_pkg::OBCD_BOR_OFF;
      2'h2: cfg_nxt.brownout_threshold_sel = obcd_pkg::OBCD_BOR_HIGHEST;
      2'h1: cfg_nxt.brownout_threshold_sel = obcd_pkg::OBCD_BOR_MEDIUM;
      default: cfg_nxt.brownout_threshold_sel = obcd_pkg::OBCD_BOR_LOWEST;
    endcase
    cfg_nxt.wdog_halt_reset = byte1_r[obcd_pkg::OBCD_B1_WDOG_HALT_BIT];
    cfg_nxt.wdog_soft_start = byte1_r[obcd_pkg::OBCD_B1_WDOG_SOFT_BIT];
    cfg_nxt.wdog_hw_enable = !byte1_r[obcd_pkg::OBCD_B1_WDOG_SOFT_BIT];
  end

  // Outputs refresh only out of reset and then stay fixed.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_cfg <= '0;
    end else begin
      o_cfg <= cfg_nxt;
    end
  end

  // Port C moves between the two interrupt lines with the map bit.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ext_irq0 <= 1'b0;
    end else if (o_cfg.irq_port_map_sel) begin
      o_ext_irq0 <= |i_port_a_irq;
    end else begin
      o_ext_irq0 <= (|i_port_a_irq) || (|i_port_c_irq);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ext_irq1 <= 1'b0;
    end else if (o_cfg.irq_port_map_sel) begin
      o_ext_irq1 <= (|i_port_b_irq) || (|i_port_c_irq);
    end else begin
      o_ext_irq1 <= |i_port_b_irq;
    end
  end

  // Read-out gate for external program memory access.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_ext_readout_allow <= 1'b0;
    end else begin
      o_ext_readout_allow <= i_ext_readout_req && !o_cfg.readout_protect;
    end
  end

  // Halt entry handling while the watchdog is running.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_halt_reset_req <= 1'b0;
    end else begin
      o_halt_reset_req <= i_halt_entry && i_wdog_running && o_cfg.wdog_halt_reset;
    end
  end

  // A halt that does not reset is always let through, watchdog running or not.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_halt_allow <= 1'b0;
    end else begin
      o_halt_allow <= i_halt_entry && !(i_wdog_running && o_cfg.wdog_halt_reset);
    end
  end

  // Erase sweep over the whole program memory with the latched data value.
  // The sweep survives reset so a partially erased memory is never left readable.
  always_ff @(posedge i_sys_clk) begin
    if (!i_prog_mode && er_state_r == OBCD_ER_DONE) begin
      er_state_r <= OBCD_ER_IDLE;
    end else begin
      case (er_state_r)
        OBCD_ER_IDLE: begin
          if (erase_start) begin
            er_state_r <= OBCD_ER_SWEEP;
          end
        end
        OBCD_ER_SWEEP: begin
          if (er_addr_r == obcd_pkg::OBCD_PMEM_LAST) begin
            er_state_r <= OBCD_ER_DONE;
          end
        end
        OBCD_ER_DONE: begin
          // A second clear in the same session must erase the memory again.
          if (erase_start) begin
            er_state_r <= OBCD_ER_SWEEP;
          end
        end
        default: er_state_r <= OBCD_ER_IDLE;
      endcase
    end
  end

  // The address returns to zero as the sweep leaves its last location.
  always_ff @(posedge i_sys_clk) begin
    if (er_state_r == OBCD_ER_SWEEP) begin
      er_addr_r <= er_addr_r + 13'h0001;
    end else begin
      er_addr_r <= 13'h0000;
    end
  end

  // Reset leaves a running sweep alone so the memory is never left half erased.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst && er_state_r != OBCD_ER_SWEEP) begin
      o_pmem_erase_we <= 1'b0;
    end else begin
      o_pmem_erase_we <= er_state_r == OBCD_ER_SWEEP;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst && er_state_r != OBCD_ER_SWEEP) begin
      o_pmem_erase_addr <= 13'h0000;
    end else begin
      o_pmem_erase_addr <= er_addr_r;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst && er_state_r != OBCD_ER_SWEEP) begin
      o_pmem_erase_data <= 8'h00;
    end else begin
      o_pmem_erase_data <= i_pmem_latch_data;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst && er_state_r != OBCD_ER_SWEEP) begin
      o_pmem_erase_busy <= 1'b0;
    end else begin
      o_pmem_erase_busy <= er_state_r == OBCD_ER_SWEEP;
    end
  end

endmodule
`default_nettype wire

// file: obcd_top_monitor.sv
// Port-level checks for the option byte decoder.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module obcd_top_monitor (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_prog_mode,
  input wire logic o_prog_rvalid,
  input wire logic [7:0] i_port_a_irq,
  input wire logic [7:0] i_port_b_irq,
  input wire logic [5:0] i_port_c_irq,
  input wire logic o_ext_irq0,
  input wire logic o_ext_irq1,
  input wire logic i_ext_readout_req,
  input wire logic o_ext_readout_allow,
  input wire logic o_pmem_erase_we,
  input wire logic [12:0] o_pmem_erase_addr,
  input wire logic i_halt_entry,
  input wire logic i_wdog_running,
  input wire logic o_halt_reset_req,
  input wire logic o_halt_allow,
  input wire obcd_pkg::obcd_cfg_t o_cfg
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [1:0] up_r;
  logic run;
  // The decode is only trusted once one edge has passed since reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      up_r <= 2'h0;
    end else if (up_r != 2'h2) begin
      up_r <= up_r + 2'h1;
    end
  end
  assign run = (up_r != 2'h0) && !i_rst;
  sequence s_first;
    o_pmem_erase_we && o_pmem_erase_addr == 13'h0;
  endsequence
  sequence s_second;
    o_pmem_erase_we && o_pmem_erase_addr == 13'h1;
  endsequence
  AST_IRQ0: assert property (run |=> o_ext_irq0 == ($past(|i_port_a_irq) ||
    (!$past(o_cfg.irq_port_map_sel) && $past(|i_port_c_irq)))) else $error("irq0 bad");
  AST_IRQ1: assert property (run |=> o_ext_irq1 == ($past(|i_port_b_irq) ||
    ($past(o_cfg.irq_port_map_sel) && $past(|i_port_c_irq)))) else $error("irq1 bad");
  AST_READOUT: assert property (run |=> o_ext_readout_allow ==
    ($past(i_ext_readout_req) && !$past(o_cfg.readout_protect))) else $error("readout bad");
  AST_HALT_RST: assert property (run && i_halt_entry && i_wdog_running &&
    o_cfg.wdog_halt_reset |=> o_halt_reset_req && !o_halt_allow) else $error("halt reset bad");
  AST_HALT_OK: assert property (run && i_halt_entry && !(i_wdog_running &&
    o_cfg.wdog_halt_reset) |=> o_halt_allow && !o_halt_reset_req) else $error("halt bad");
  AST_CFG_HOLD: assert property (run |=> $stable(o_cfg)) else $error("cfg moved");
  AST_REFUSE: assert property (!i_prog_mode |=> !o_prog_rvalid) else $error("rvalid bad");
  AST_SWEEP: assert property ($rose(o_pmem_erase_we) |-> s_first ##1 s_second)
    else $error("sweep order bad");
endmodule
bind obcd_top obcd_top_monitor u_mon (.i_sys_clk, .i_rst, .i_prog_mode, .o_prog_rvalid,
  .i_port_a_irq, .i_port_b_irq, .i_port_c_irq, .o_ext_irq0, .o_ext_irq1, .i_ext_readout_req,
  .o_ext_readout_allow, .o_pmem_erase_we, .o_pmem_erase_addr, .i_halt_entry,
  .i_wdog_running, .o_halt_reset_req, .o_halt_allow, .o_cfg);
`default_nettype wire

// file: option_byte_config_decoder_tb_top.sv
// Self-checking bench for the option byte decoder.
// Assumes the tool model drives the programming port.
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_decoder_tb_top;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] a = 8'h00, b = 8'h00, lat = 8'h5a, rdata, edata;
  logic [5:0] c = 6'h00;
  logic req = 1'b0, halt = 1'b0, wrun = 1'b1;
  logic mode, rv, irq0, irq1, ok, we, busy, rst_req, h_ok;
  logic [12:0] addr;
  obcd_pkg::obcd_prog_req_t preq;
  obcd_pkg::obcd_cfg_t cfg, exp;
  int n_fail = 0, n_compared = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  obcd_top uut (.i_sys_clk, .i_rst, .i_prog_mode(mode), .i_prog_req(preq), .o_prog_rdata(rdata),
    .o_prog_rvalid(rv), .i_port_a_irq(a), .i_port_b_irq(b), .i_port_c_irq(c), .o_ext_irq0(irq0),
    .o_ext_irq1(irq1), .i_ext_readout_req(req), .o_ext_readout_allow(ok),
    .i_pmem_latch_data(lat), .o_pmem_erase_we(we), .o_pmem_erase_addr(addr),
    .o_pmem_erase_data(edata), .o_pmem_erase_busy(busy), .i_halt_entry(halt),
    .i_wdog_running(wrun), .o_halt_reset_req(rst_req), .o_halt_allow(h_ok), .o_cfg(cfg));
  obcd_tool_model tool (.i_sys_clk, .i_prog_rdata(rdata), .o_prog_mode(mode), .o_prog_req(preq));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp_v);
    n_compared++;
    if (seen !== exp_v) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp_v, seen);
    end
  endtask
  task automatic results;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  function automatic obcd_pkg::obcd_cfg_t dec(input logic [7:0] b0, input logic [7:0] b1);
    obcd_pkg::obcd_cfg_t e;
    logic [2:0] o;
    o = b1[6:4];
    e.irq_port_map_sel = b0[1];
    e.readout_protect = b0[0];
    e.clock_glitch_filter = !b1[7];
    e.main_osc_select = obcd_pkg::obcd_osc_t'(o[2] ? (o[1] ? o - 3'h1 : 3'h4) : o);
    e.brownout_threshold_sel = obcd_pkg::obcd_bor_t'(b1[3:2]);
    e.wdog_halt_reset = b1[1];
    e.wdog_soft_start = b1[0];
    e.wdog_hw_enable = !b1[0];
    return e;
  endfunction
  task automatic t_reset;
    i_rst = 1'b1;
    tk(3);
    i_rst = 1'b0;
    tk(1);
  endtask
  task automatic t_defaults;
    tool.acc(1'b0, 1'b0, 8'h00);
    chk("rvalid", 16'(rv), 16'h0001);
    chk("byte0 blank", 16'(tool.rd_val), 16'h00ff);
    tool.mode = 1'b0;
    tool.acc(1'b1, 1'b1, 8'h00);
    tool.acc(1'b0, 1'b1, 8'h00);
    chk("rvalid refused", 16'(rv), 16'h0000);
    tool.mode = 1'b1;
    tool.acc(1'b0, 1'b1, 8'h00);
    chk("byte1 refused", 16'(tool.rd_val), 16'h00ff);
    chk("cfg blank", 16'(cfg), 16'(dec(8'hff, 8'hff)));
    $display("defaults done");
  endtask
  task automatic t_gates(input logic m, input logic p);
    c = 6'h20;
    req = 1'b1;
    tk(1);
    chk("irq0 c", 16'(irq0), 16'(!m));
    chk("irq1 c", 16'(irq1), 16'(m));
    chk("readout", 16'(ok), 16'(!p));
    a = 8'h80;
    b = 8'h01;
    c = 6'h00;
    req = 1'b0;
    tk(1);
    a = 8'h00;
    b = 8'h00;
    chk("irq0 a", 16'(irq0), 16'h0001);
    chk("irq1 b", 16'(irq1), 16'h0001);
    chk("readout idle", 16'(ok), 16'h0000);
    $display("gates done");
  endtask
  task automatic t_halt(input logic hr);
    halt = 1'b1;
    tk(1);
    halt = 1'b0;
    chk("halt reset", 16'(rst_req), 16'(hr));
    chk("halt allow", 16'(h_ok), 16'(!hr));
  endtask
  task automatic t_osc;
    logic [7:0] v;
    logic [2:0] k;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      v = {~k[0], k, k[1:0], k[2], k[0]};
      exp = cfg;
      tool.acc(1'b1, 1'b1, v);
      tk(2);
      chk("cfg held", 16'(cfg), 16'(exp));
      t_reset();
      chk("cfg decode", 16'(cfg), 16'(dec(8'hff, v)));
      t_halt(v[1]);
    end
    $display("options done");
  endtask
  task automatic t_erase;
    int n;
    n = 0;
    tool.acc(1'b1, 1'b0, 8'hfc);
    while (we !== 1'b1 && n < 8) begin
      tk(1);
      n++;
    end
    chk("erase start", 16'(addr), 16'h0000);
    chk("erase data", 16'(edata), 16'(lat));
    chk("erase busy", 16'(busy), 16'h0001);
    n = 0;
    while (we === 1'b1 && n < 9000) begin
      n++;
      tk(1);
    end
    chk("erase count", n[15:0], 16'h2000);
    chk("erase idle", 16'(busy), 16'h0000);
    tool.acc(1'b0, 1'b0, 8'h00);
    chk("byte0 kept", 16'(tool.rd_val), 16'h00fc);
    $display("erase done");
  endtask
  initial begin
    tk(5);
    i_rst = 1'b0;
    tk(1);
    t_defaults();
    t_gates(1'b1, 1'b1);
    t_osc();
    t_erase();
    t_reset();
    t_gates(1'b0, 1'b0);
    results();
  end
  initial begin
    #60000;
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
